// >>> rtl/reset_release_sync.v
// Reset synchroniser: asserts at once, releases once the second and third of three chained flops are both high.
`timescale 1ns/100ps
module reset_release_sync (
    // Clock and asynchronous low reset
    input  wire clock,
    input  wire async_low,
    // Synchronised low reset
    output reg  sync_low_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // =====================================================
    // Release chain
    always @(posedge clock or negedge async_low) begin
        if (!async_low) begin
            s1_q       <= 1'b0;
            s2_q       <= 1'b0;
            s3_q       <= 1'b0;
            sync_low_q <= 1'b0;
        end else begin
            s1_q       <= 1'b1;
            s2_q       <= s1_q;
            s3_q       <= s2_q;
            sync_low_q <= s2_q & s3_q;
        end
    end
endmodule // reset_release_sync

// >>> rtl/sample_fifo.v
// Sample FIFO with registered ready, valid and data.
`timescale 1ns/100ps
module sample_fifo #(
    parameter W     = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire         clock,
    input  wire         rst_n,
    // Fill side
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output reg          in_ready_q,
    // Drain side
    output reg  [W-1:0] out_data_q,
    output reg          out_valid_q,
    input  wire         out_ready
);
    reg  [W-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0] wr_ptr_q;
    reg  [AW-1:0] rd_ptr_q;
    reg  [AW:0]   cnt_q;
    reg  [AW:0]   cnt_d;
    wire push = in_valid & in_ready_q;
    wire load = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready);

    // =====================================================
    // Occupancy
    always @* begin
        case ({push, load})
            2'b10:   cnt_d = cnt_q + 1'b1;
            2'b01:   cnt_d = cnt_q - 1'b1;
            default: cnt_d = cnt_q;
        endcase
    end

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_q] <= in_data;
        end
    end

    // =====================================================
    // Pointers and output stage
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q    <= {AW{1'b0}};
            rd_ptr_q    <= {AW{1'b0}};
            cnt_q       <= {(AW+1){1'b0}};
            in_ready_q  <= 1'b0;
            out_valid_q <= 1'b0;
            out_data_q  <= {W{1'b0}};
        end else begin
            cnt_q      <= cnt_d;
            in_ready_q <= (cnt_d != DEPTH[AW:0]);
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (load) begin
                rd_ptr_q    <= rd_ptr_q + 1'b1;
                out_data_q  <= mem[rd_ptr_q];
                out_valid_q <= 1'b1;
            end else if (out_ready) begin
                out_valid_q <= 1'b0;
            end
        end
    end
endmodule // sample_fifo

// >>> rtl/tx_clock_plan_defs.vh
// Constants for the transmit clock and reset plan block.
// =====================================================
// Operation
// - Link word every 132 lane bits.
// - Frame strobe 1x, 2x or 4x link.
// - Word phase reference times link transfers.
// - Frame phase reference times frame transfers.
// - Low async reset for link, transport layers.
// - Separate low async reset for serdes.
// - Own low async reset for management port.
// - High reconf reset, shared in duplex.
// - Management port crosses domains safely.
// - Management slave reads control, status, writes control.
// - Sample stream runs on frame strobe.
// - Control samples run on frame strobe.
// - Commands run on link strobe.
// - PHY only, MAC only or both.
// - Combined build bonds lanes.
// - Management data 32 bits, byte addressed.
`ifndef TX_CLOCK_PLAN_DEFS_VH
`define TX_CLOCK_PLAN_DEFS_VH

// =====================================================
// Timing
`define BITS_PER_LINK   8'h84
`define BITS_PER_CYCLE  8'h21

// =====================================================
// Modes
`define MULT_1X         2'h0
`define MULT_2X         2'h1
`define MULT_4X         2'h2
`define CFG_PHY_ONLY    2'h0
`define CFG_MAC_ONLY    2'h1
`define CFG_MAC_PHY     2'h2

// =====================================================
// Management map
`define MGMT_CTRL_ADDR  10'h000
`define MGMT_STAT_ADDR  10'h004
`define MGMT_CTRL_RST   32'h00000001
`define CTRL_LANE_EN    0

// =====================================================
// Sizes
`define DATA_W          32
`define CMD_W           16
`define CTRL_W          4
`define FIFO_DEPTH      16
`define FIFO_AW         4

`endif

// >>> rtl/tx_link_clock_reset_plan.v
// Transmit clock strobes, reset domains, streams and management port.
`timescale 1ns/100ps
`include "tx_clock_plan_defs.vh"
module tx_link_clock_reset_plan (
    // Clock and reset
    input  wire                clock,
    input  wire                reset_n,
    // Domain resets
    input  wire                tx_mac_reset_low,
    input  wire                tx_serdes_reset_low,
    input  wire                tx_mgmt_reset_low,
    input  wire                xcvr_reconf_reset_high,
    input  wire                duplex_mode,
    // Build straps
    input  wire [1:0]          core_config,
    input  wire [1:0]          frame_mult_sel,
    // Sample stream
    input  wire [`DATA_W-1:0]  sample_data,
    input  wire                sample_valid,
    output wire                sample_ready,
    // Control sample stream
    input  wire [`CTRL_W-1:0]  ctrl_sample,
    input  wire                ctrl_sample_valid,
    output reg                 ctrl_sample_ready_q,
    // Command stream
    input  wire [`CMD_W-1:0]   cmd_data,
    input  wire                cmd_valid,
    output reg                 cmd_ready_q,
    // External MAC into PHY
    input  wire [`DATA_W-1:0]  mac_if_data,
    input  wire                mac_if_valid,
    // Lane side
    output reg  [`DATA_W-1:0]  serdes_data_q,
    output reg  [`CTRL_W-1:0]  serdes_ctrl_q,
    output reg  [`CMD_W-1:0]   serdes_cmd_q,
    output reg                 serdes_valid_q,
    output reg  [`DATA_W-1:0]  mac_if_out_q,
    output reg                 mac_if_out_valid_q,
    output reg                 lane_bond_q,
    // Phase references
    output reg                 word_phase_ref_q,
    output reg                 frame_phase_ref_q,
    // Reset outputs
    output wire                mac_reset_low_q,
    output wire                serdes_reset_low_q,
    output wire                mgmt_reset_low_q,
    output reg                 reconf_reset_high_q,
    output reg                 rx_reconf_reset_high_q,
    // Management port
    input  wire                mgmt_req_toggle,
    input  wire                mgmt_write,
    input  wire [9:0]          mgmt_address,
    input  wire [31:0]         mgmt_writedata,
    output reg                 mgmt_ack_toggle_q,
    output reg  [31:0]         mgmt_readdata_q,
    output reg                 mgmt_error_q
);
    reg                rst_meta_q;
    reg                rst_n_q;
    wire               reconf_rst_n;
    reg                cfg_taken_q;
    reg  [1:0]         core_cfg_q;
    reg  [1:0]         mult_q;
    reg  [7:0]         bit_cnt_q;
    reg  [7:0]         bit_cnt_d;
    reg  [1:0]         slot_q;
    reg  [1:0]         slot_d;
    reg                link_en_q;
    reg                frame_en_d;
    reg                frame_en_q;
    reg  [`DATA_W-1:0] frame_word_q;
    reg  [`CTRL_W-1:0] ctrl_word_q;
    wire [`DATA_W-1:0] fifo_data;
    wire               fifo_valid;
    wire               fifo_take;
    reg  [31:0]        ctrl_q;
    reg                tog1_q;
    reg                tog2_q;
    reg                tog3_q;
    reg                tog_seen_q;
    wire               mgmt_event;
    wire               addr_bad;
    wire [31:0]        status_word;
    wire               lane_en;

    // =====================================================
    // Reset release
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    reset_release_sync mac_sync (
        .clock      (clock),
        .async_low  (tx_mac_reset_low & reset_n),
        .sync_low_q (mac_reset_low_q)
    );

    reset_release_sync serdes_sync (
        .clock      (clock),
        .async_low  (tx_serdes_reset_low & reset_n),
        .sync_low_q (serdes_reset_low_q)
    );

    reset_release_sync mgmt_sync (
        .clock      (clock),
        .async_low  (tx_mgmt_reset_low & reset_n),
        .sync_low_q (mgmt_reset_low_q)
    );

    reset_release_sync reconf_sync (
        .clock      (clock),
        .async_low  (~xcvr_reconf_reset_high & reset_n),
        .sync_low_q (reconf_rst_n)
    );

    // Receive side only shares the reconfiguration reset in duplex builds.
    always @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reconf_reset_high_q    <= 1'b1;
            rx_reconf_reset_high_q <= 1'b0;
        end else begin
            reconf_reset_high_q    <= ~reconf_rst_n;
            rx_reconf_reset_high_q <= duplex_mode & ~reconf_rst_n;
        end
    end

    // =====================================================
    // Build straps
    // Straps are static, so they are caught once after reset release.
    always @(posedge clock or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cfg_taken_q <= 1'b0;
            core_cfg_q  <= `CFG_MAC_PHY;
            mult_q      <= `MULT_1X;
            lane_bond_q <= 1'b0;
        end else begin
            if (!cfg_taken_q) begin
                cfg_taken_q <= 1'b1;
                core_cfg_q  <= core_config;
                mult_q      <= frame_mult_sel;
            end
            lane_bond_q <= cfg_taken_q & (core_cfg_q == `CFG_MAC_PHY);
        end
    end

    // =====================================================
    // Link and frame strobes
    always @* begin
        bit_cnt_d = bit_cnt_q + `BITS_PER_CYCLE;
        slot_d    = slot_q + 1'b1;
        if (bit_cnt_d == `BITS_PER_LINK) begin
            bit_cnt_d = 8'h00;
            slot_d    = 2'h0;
        end
        case (mult_q)
            `MULT_2X: frame_en_d = ~slot_d[0];
            `MULT_4X: frame_en_d = 1'b1;
            default:  frame_en_d = (slot_d == 2'h0);
        endcase
    end

    always @(posedge clock or negedge mac_reset_low_q) begin
        if (!mac_reset_low_q) begin
            bit_cnt_q           <= 8'h00;
            slot_q              <= 2'h0;
            link_en_q           <= 1'b0;
            frame_en_q          <= 1'b0;
            cmd_ready_q         <= 1'b0;
            ctrl_sample_ready_q <= 1'b0;
            word_phase_ref_q    <= 1'b0;
            frame_phase_ref_q   <= 1'b0;
        end else if (cfg_taken_q) begin
            bit_cnt_q           <= bit_cnt_d;
            slot_q              <= slot_d;
            link_en_q           <= (slot_d == 2'h0);
            frame_en_q          <= frame_en_d;
            cmd_ready_q         <= (slot_d == 2'h0);
            ctrl_sample_ready_q <= frame_en_d;
            if (slot_d == 2'h0) begin
                word_phase_ref_q <= ~word_phase_ref_q;
            end
            if (frame_en_d) begin
                frame_phase_ref_q <= ~frame_phase_ref_q;
            end
        end
    end

    // =====================================================
    // Sample buffer
    assign lane_en   = ctrl_q[`CTRL_LANE_EN];
    assign fifo_take = frame_en_q & lane_en & (core_cfg_q != `CFG_PHY_ONLY);

    sample_fifo #(
        .W     (`DATA_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) fifo (
        .clock       (clock),
        .rst_n       (mac_reset_low_q),
        .in_data     (sample_data),
        .in_valid    (sample_valid),
        .in_ready_q  (sample_ready),
        .out_data_q  (fifo_data),
        .out_valid_q (fifo_valid),
        .out_ready   (fifo_take)
    );

    // =====================================================
    // Frame side
    // An empty buffer sends zeros rather than stalling the lane.
    always @(posedge clock or negedge mac_reset_low_q) begin
        if (!mac_reset_low_q) begin
            frame_word_q <= {`DATA_W{1'b0}};
            ctrl_word_q  <= {`CTRL_W{1'b0}};
        end else if (fifo_take) begin
            frame_word_q <= fifo_valid ? fifo_data : {`DATA_W{1'b0}};
            ctrl_word_q  <= ctrl_sample_valid ? ctrl_sample : {`CTRL_W{1'b0}};
        end
    end

    // =====================================================
    // Link side, MAC boundary
    // Frame data crosses on the link strobe, which is word phase zero.
    always @(posedge clock or negedge mac_reset_low_q) begin
        if (!mac_reset_low_q) begin
            mac_if_out_q       <= {`DATA_W{1'b0}};
            mac_if_out_valid_q <= 1'b0;
            serdes_ctrl_q      <= {`CTRL_W{1'b0}};
            serdes_cmd_q       <= {`CMD_W{1'b0}};
        end else begin
            mac_if_out_valid_q <= 1'b0;
            if (link_en_q & lane_en & (core_cfg_q != `CFG_PHY_ONLY)) begin
                mac_if_out_q       <= frame_word_q;
                mac_if_out_valid_q <= 1'b1;
                serdes_ctrl_q      <= ctrl_word_q;
                serdes_cmd_q       <= cmd_valid ? cmd_data : {`CMD_W{1'b0}};
            end
        end
    end

    // =====================================================
    // Lane side, PHY
    always @(posedge clock or negedge serdes_reset_low_q) begin
        if (!serdes_reset_low_q) begin
            serdes_data_q  <= {`DATA_W{1'b0}};
            serdes_valid_q <= 1'b0;
        end else begin
            serdes_valid_q <= 1'b0;
            case (core_cfg_q)
                `CFG_PHY_ONLY: begin
                    if (link_en_q & mac_if_valid) begin
                        serdes_data_q  <= mac_if_data;
                        serdes_valid_q <= 1'b1;
                    end
                end
                `CFG_MAC_PHY: begin
                    if (mac_if_out_valid_q) begin
                        serdes_data_q  <= mac_if_out_q;
                        serdes_valid_q <= 1'b1;
                    end
                end
                default: begin
                    serdes_data_q <= {`DATA_W{1'b0}};
                end
            endcase
        end
    end

    // =====================================================
    // Management port crossing
    // Fields are held by the master until the ack toggle returns.
    always @(posedge clock or negedge mgmt_reset_low_q) begin
        if (!mgmt_reset_low_q) begin
            tog1_q     <= 1'b0;
            tog2_q     <= 1'b0;
            tog3_q     <= 1'b0;
            tog_seen_q <= 1'b0;
        end else begin
            tog1_q <= mgmt_req_toggle;
            tog2_q <= tog1_q;
            tog3_q <= tog2_q;
            if (mgmt_event) begin
                tog_seen_q <= tog3_q;
            end
        end
    end

    assign mgmt_event  = (tog2_q == tog3_q) & (tog3_q != tog_seen_q);
    assign addr_bad    = (mgmt_address[1:0] != 2'h0);
    assign status_word = {22'h0, lane_bond_q, sample_ready, fifo_valid,
                          serdes_reset_low_q, mac_reset_low_q, cfg_taken_q,
                          core_cfg_q, mult_q};

    // =====================================================
    // Management registers
    always @(posedge clock or negedge mgmt_reset_low_q) begin
        if (!mgmt_reset_low_q) begin
            ctrl_q            <= `MGMT_CTRL_RST;
            mgmt_ack_toggle_q <= 1'b0;
            mgmt_readdata_q   <= 32'h00000000;
            mgmt_error_q      <= 1'b0;
        end else if (mgmt_event) begin
            mgmt_ack_toggle_q <= tog3_q;
            mgmt_error_q      <= 1'b0;
            mgmt_readdata_q   <= 32'h00000000;
            if (addr_bad) begin
                mgmt_error_q <= 1'b1;
            end else if (mgmt_address == `MGMT_CTRL_ADDR) begin
                if (mgmt_write) begin
                    ctrl_q <= mgmt_writedata;
                end else begin
                    mgmt_readdata_q <= ctrl_q;
                end
            end else if (mgmt_address == `MGMT_STAT_ADDR) begin
                if (mgmt_write) begin
                    mgmt_error_q <= 1'b1;
                end else begin
                    mgmt_readdata_q <= status_word;
                end
            end else begin
                mgmt_error_q <= 1'b1;
            end
        end
    end
endmodule // tx_link_clock_reset_plan

// >>> testbench/lane_sink_model.sv
// Data converter model taking lane words.
`timescale 1ns/100ps
module lane_sink_model (
    // Clock and lane words
    input  wire        clock,
    input  wire [31:0] lane_data,
    input  wire        lane_valid,
    // Summary of what arrived
    output reg  [31:0] word_gap,
    output reg  [31:0] nz_count,
    output reg  [31:0] nz_last
);
    reg [31:0] since_q = 32'h0;
    initial {word_gap, nz_count, nz_last} = 96'h0;
    // Zero words are idle filler, so they are not counted.
    always @(posedge clock) begin
        since_q <= since_q + 32'h1;
        if (lane_valid === 1'h1) begin
            word_gap <= since_q + 32'h1;
            since_q <= 32'h0;
            if (lane_data !== 32'h0) begin
                nz_count <= nz_count + 32'h1;
                nz_last <= lane_data;
            end
        end
    end
endmodule // lane_sink_model

// >>> testbench/tx_link_clock_reset_plan_monitor.sv
// Checker of strobes, resets, lanes and management timing.
`timescale 1ns/100ps
`include "tx_clock_plan_defs.vh"
module tx_plan_checker (
    // Clock, straps and resets
    input logic               clock, reset_n, duplex_mode, xcvr_reconf_reset_high,
    input logic               tx_serdes_reset_low, tx_mgmt_reset_low,
    input logic [1:0]         core_config, frame_mult_sel,
    input logic               mac_reset_low_q, serdes_reset_low_q, mgmt_reset_low_q,
    input logic               reconf_reset_high_q, rx_reconf_reset_high_q,
    // Strobes and lanes
    input logic               ctrl_sample_ready_q, cmd_ready_q, word_phase_ref_q,
    input logic [`DATA_W-1:0] serdes_data_q, mac_if_out_q,
    input logic               serdes_valid_q, mac_if_out_valid_q, lane_bond_q,
    // Management port
    input logic               mgmt_req_toggle, mgmt_ack_toggle_q, mgmt_error_q,
    input logic [9:0]         mgmt_address
);
    default clocking mon_cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // =====================================================
    // Strobes
    // Periods are not judged while the link layer is held.
    a_word_period: assert property (disable iff (!mac_reset_low_q)
        $changed(word_phase_ref_q) |=> (!$changed(word_phase_ref_q))[*3]
        ##1 $changed(word_phase_ref_q)) else $error("word period wrong");
    a_cmd_period: assert property (disable iff (!mac_reset_low_q)
        cmd_ready_q |=> (!cmd_ready_q)[*3] ##1 cmd_ready_q)
        else $error("cmd period wrong");
    a_frame_double: assert property (disable iff (!mac_reset_low_q)
        (frame_mult_sel == `MULT_2X && ctrl_sample_ready_q) |=> !ctrl_sample_ready_q
        ##1 ctrl_sample_ready_q) else $error("2x frame wrong");
    a_frame_quad: assert property (disable iff (!mac_reset_low_q)
        (frame_mult_sel == `MULT_4X && ctrl_sample_ready_q) |=> ctrl_sample_ready_q)
        else $error("4x frame wrong");
    // =====================================================
    // Resets
    a_serdes_hold: assert property (!tx_serdes_reset_low |-> !serdes_reset_low_q)
        else $error("serdes reset missed");
    a_mgmt_hold: assert property (!tx_mgmt_reset_low |-> !mgmt_reset_low_q)
        else $error("mgmt reset missed");
    a_serdes_release: assert property ($rose(tx_serdes_reset_low) |->
        !serdes_reset_low_q ##1 !serdes_reset_low_q ##[1:8] serdes_reset_low_q)
        else $error("serdes release late");
    a_duplex_share: assert property ($rose(reconf_reset_high_q) && duplex_mode |->
        ##[0:2] rx_reconf_reset_high_q) else $error("rx reconf not shared");
    // =====================================================
    // Management and lanes
    a_mgmt_answer: assert property (disable iff (!mgmt_reset_low_q)
        $changed(mgmt_req_toggle) |=> mgmt_ack_toggle_q != mgmt_req_toggle
        ##[1:6] mgmt_ack_toggle_q == mgmt_req_toggle) else $error("mgmt answer late");
    a_mgmt_unaligned: assert property ($changed(mgmt_ack_toggle_q)
        && mgmt_address[1:0] != 2'h0 |-> mgmt_error_q) else $error("unaligned access accepted");
    a_lane_follow: assert property (disable iff (!mac_reset_low_q || !serdes_reset_low_q)
        (core_config == `CFG_MAC_PHY && mac_if_out_valid_q && serdes_reset_low_q) |=>
        serdes_valid_q && serdes_data_q == $past(mac_if_out_q)) else $error("lane word lost");
    a_lane_bond: assert property (serdes_valid_q |->
        lane_bond_q == (core_config == `CFG_MAC_PHY)) else $error("lane bonding wrong");
endmodule // tx_plan_checker

bind tx_link_clock_reset_plan tx_plan_checker chk_u (.*);

// >>> testbench/tx_link_clock_reset_plan_tb_top.sv
// Bench for the transmit clock and reset plan block.
`timescale 1ns/100ps
`include "tx_clock_plan_defs.vh"
module tx_link_clock_reset_plan_tb_top;
    // =====================================================
    // Signals
    logic clock = 1'h0, reset_n = 1'h0, duplex_mode = 1'h1, xcvr_reconf_reset_high = 1'h0;
    logic tx_mac_reset_low = 1'h1, tx_serdes_reset_low = 1'h1, tx_mgmt_reset_low = 1'h1;
    logic sample_valid = 1'h0, ctrl_sample_valid = 1'h0, cmd_valid = 1'h0, mac_if_valid = 1'h0;
    logic mgmt_req_toggle = 1'h0, mgmt_write = 1'h0;
    logic [1:0]  core_config = 2'h0, frame_mult_sel = 2'h0;
    logic [31:0] sample_data = 32'h0, mac_if_data = 32'h0, mgmt_writedata = 32'h0;
    logic [3:0]  ctrl_sample = 4'h0, serdes_ctrl_q;
    logic [15:0] cmd_data = 16'h0, serdes_cmd_q;
    logic [9:0]  mgmt_address = 10'h0;
    logic [31:0] serdes_data_q, mac_if_out_q, mgmt_readdata_q, word_gap, nz_count, nz_last, rd;
    logic sample_ready, ctrl_sample_ready_q, cmd_ready_q, serdes_valid_q, mac_if_out_valid_q;
    logic lane_bond_q, word_phase_ref_q, frame_phase_ref_q, mac_reset_low_q, serdes_reset_low_q;
    logic mgmt_reset_low_q, reconf_reset_high_q, rx_reconf_reset_high_q;
    logic mgmt_ack_toggle_q, mgmt_error_q, er;
    int   error_cnt = 0, checks_done = 0, cyc = 0;

    tx_link_clock_reset_plan dut_u (.*);
    lane_sink_model sink_u (.clock(clock), .lane_data(serdes_data_q), .lane_valid(serdes_valid_q),
                            .word_gap(word_gap), .nz_count(nz_count), .nz_last(nz_last));

    initial forever #4 clock = ~clock;
    // =====================================================
    // Reporting
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            final_report;
        end
    end
    // =====================================================
    // Shared drivers
    task automatic restart(input logic [1:0] cfg, input logic [1:0] mult);
        @(negedge clock);
        reset_n = 1'h0;
        core_config = cfg;
        frame_mult_sel = mult;
        repeat (16) @(negedge clock);
        reset_n = 1'h1;
        repeat (12) @(negedge clock);
    endtask
    // The port shares the strobes' clock, which its frequency range permits.
    task automatic mgmt(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n = 0;
        @(negedge clock);
        mgmt_write = w;
        mgmt_address = a;
        mgmt_writedata = d;
        mgmt_req_toggle = ~mgmt_req_toggle;
        while (mgmt_ack_toggle_q !== mgmt_req_toggle && n < 20) begin
            @(negedge clock);
            n++;
        end
        rd = mgmt_readdata_q;
        er = mgmt_error_q;
        check(n < 20, 32'h1);
        @(negedge clock);
    endtask
    // =====================================================
    // Scenarios
    task automatic t_rates;
        for (int i = 0; i < 3; i++) begin
            int f = 0, c = 0, w = 0, fr = 0;
            logic pw, pf;
            restart(`CFG_MAC_PHY, i == 0 ? `MULT_1X : i == 1 ? `MULT_2X : `MULT_4X);
            cmd_data = 16'h5A30 + 16'(i);
            cmd_valid = 1'h1;
            ctrl_sample = 4'h9;
            ctrl_sample_valid = 1'h1;
            pw = word_phase_ref_q;
            pf = frame_phase_ref_q;
            repeat (32) begin
                @(negedge clock);
                f += (ctrl_sample_ready_q === 1'h1);
                c += (cmd_ready_q === 1'h1);
                w += (word_phase_ref_q !== pw);
                fr += (frame_phase_ref_q !== pf);
                pw = word_phase_ref_q;
                pf = frame_phase_ref_q;
            end
            check(c, 32'h8);
            check(w, 32'h8);
            check(f, 32'h8 << i);
            check(fr, 32'h8 << i);
            check({16'h0, serdes_cmd_q}, 32'h5A30 + i);
            check({28'h0, serdes_ctrl_q}, 32'h9);
        end
    endtask
    task automatic t_builds;
        logic seen = 1'h0;
        restart(`CFG_PHY_ONLY, `MULT_1X);
        mac_if_data = 32'h3C5A0F96;
        mac_if_valid = 1'h1;
        repeat (12) @(negedge clock);
        check(serdes_data_q, 32'h3C5A0F96);
        check(lane_bond_q, 32'h0);
        mac_if_valid = 1'h0;
        restart(`CFG_MAC_ONLY, `MULT_1X);
        sample_data = 32'h77;
        sample_valid = 1'h1;
        @(negedge clock);
        sample_valid = 1'h0;
        repeat (16) begin
            @(negedge clock);
            if (mac_if_out_q === 32'h77) seen = 1'h1;
        end
        check(seen, 32'h1);
        check(serdes_data_q, 32'h0);
        restart(`CFG_MAC_PHY, `MULT_1X);
        check(lane_bond_q, 32'h1);
    endtask
    task automatic t_mgmt;
        mgmt(1'h0, `MGMT_CTRL_ADDR, 32'h0);
        check(rd, `MGMT_CTRL_RST);
        check(er, 32'h0);
        mgmt(1'h1, `MGMT_CTRL_ADDR, 32'h0);
        mgmt(1'h0, `MGMT_CTRL_ADDR, 32'h0);
        check(rd, 32'h0);
        mgmt(1'h0, `MGMT_STAT_ADDR, 32'h0);
        check({28'h0, rd[3:0]}, {28'h0, `CFG_MAC_PHY, `MULT_1X});
        mgmt(1'h1, `MGMT_STAT_ADDR, 32'h5);
        check(er, 32'h1);
        mgmt(1'h0, 10'h002, 32'h0);
        check(er, 32'h1);
        mgmt(1'h0, 10'h010, 32'h0);
        check(er, 32'h1);
    endtask
    // Lanes are disabled on entry, so the FIFO fills until it refuses.
    task automatic t_fill;
        int n = 0;
        logic rdy;
        logic [31:0] base = nz_count;
        sample_valid = 1'h1;
        repeat (30) begin
            sample_data = 32'hA5000000 + n;
            rdy = sample_ready;
            @(negedge clock);
            if (rdy === 1'h1) n++;
        end
        sample_valid = 1'h0;
        check(n, 32'h11);
        mgmt(1'h1, `MGMT_CTRL_ADDR, `MGMT_CTRL_RST);
        repeat (100) @(negedge clock);
        check(nz_count - base, 32'h11);
        check(nz_last, 32'hA5000010);
        check(word_gap, 32'h4);
    endtask
    task automatic t_resets;
        for (int i = 0; i < 3; i++) begin
            @(negedge clock);
            {tx_mac_reset_low, tx_serdes_reset_low, tx_mgmt_reset_low} = ~(3'h1 << i);
            #1;
            check({mac_reset_low_q, serdes_reset_low_q, mgmt_reset_low_q}, 32'h7 ^ (1 << i));
            @(negedge clock);
            {tx_mac_reset_low, tx_serdes_reset_low, tx_mgmt_reset_low} = 3'h7;
            repeat (12) @(negedge clock);
            check({mac_reset_low_q, serdes_reset_low_q, mgmt_reset_low_q}, 32'h7);
        end
        xcvr_reconf_reset_high = 1'h1;
        repeat (4) @(negedge clock);
        check({reconf_reset_high_q, rx_reconf_reset_high_q}, 32'h3);
        xcvr_reconf_reset_high = 1'h0;
        repeat (6) @(negedge clock);
        check({reconf_reset_high_q, rx_reconf_reset_high_q}, 32'h0);
    endtask
    // =====================================================
    // Main sequence
    initial begin
        t_rates;
        t_builds;
        t_mgmt;
        t_fill;
        t_resets;
        final_report;
    end
endmodule // tx_link_clock_reset_plan_tb_top
